// ==== rtl/spimsp_defines.svh ====
`ifndef SPIMSP_DEFINES_SVH
`define SPIMSP_DEFINES_SVH

// =====================================================================
// Select modes, taken from {select_mode_hi, select_mode_lo}.
`define SPIMSP_MODE_THREE_WIRE 2'h0
`define SPIMSP_MODE_MULTI 2'h1

// =====================================================================
// Positions of the four event flags in the flag vector.
`define SPIMSP_FLAG_DONE 0
`define SPIMSP_FLAG_COLLIDE 1
`define SPIMSP_FLAG_FAULT 2
`define SPIMSP_FLAG_OVERRUN 3

// =====================================================================
// Positions of the signals in the synchroniser vector.
`define SPIMSP_SYNC_NSS 0
`define SPIMSP_SYNC_MISO 1
`define SPIMSP_SYNC_TOGGLE 2
`define SPIMSP_SYNC_BUSY 3

// =====================================================================
// Byte framing counts.
`define SPIMSP_FIRST_EDGE 5'h01
`define SPIMSP_LAST_EDGE 5'h10
`define SPIMSP_BIT_LAST 3'h7

// =====================================================================
// Clock rate of the core and highest master bit rate, in hertz.
`define SPIMSP_SYS_CLK_HZ 20000000
`define SPIMSP_MAX_BIT_HZ 12500000
// Least half period of the master clock in core cycles, rounded up.
`define SPIMSP_MIN_HALF ((`SPIMSP_SYS_CLK_HZ + 2 * `SPIMSP_MAX_BIT_HZ - 1) / (2 * `SPIMSP_MAX_BIT_HZ))

`endif

// ==== rtl/spimsp_pkg.sv ====
// =====================================================================
// Types shared by the port, its link logic and its synchroniser.
package spimsp_pkg;

   // Master sequencer state.
   typedef enum logic [1:0] {
      spimsp_st_idle = 2'b00,
      spimsp_st_run = 2'b01
   } spimsp_state_e;

   // Whole state of the core-clock side of the port.
   typedef struct packed {
      spimsp_state_e state;
      logic master_en;
      logic port_en;
      logic [3:0] flags;
      logic [7:0] tx_buf;
      logic tx_full;
      logic [7:0] shift;
      logic shift_loaded;
      logic [7:0] rx_buf;
      logic rx_full;
      logic [7:0] div_cnt;
      logic [4:0] edge_cnt;
      logic sck;
      logic sample_bit;
      logic toggle_seen;
   } spimsp_core_s;

   // Whole state of the link-clock side of the port.
   typedef struct packed {
      logic [2:0] bit_cnt;
      logic [6:0] shift_in;
      logic [7:0] rx_hold;
      logic toggle;
      logic busy;
   } spimsp_link_s;

   // Two synchroniser stages for four signals.
   typedef struct packed {
      logic [3:0] stage1;
      logic [3:0] stage2;
   } spimsp_sync_s;

endpackage : spimsp_pkg

// ==== rtl/spimsp_link_if.sv ====
// =====================================================================
// Signals from the link-clock logic to the core-clock logic.
interface spimsp_link_if;
   logic [7:0] rx_byte;
   logic rx_toggle;
   logic busy;
   logic [2:0] bit_cnt;
   modport link (output rx_byte, output rx_toggle, output busy, output bit_cnt);
   modport core (input rx_byte, input rx_toggle, input busy, input bit_cnt);
endinterface : spimsp_link_if

// ==== rtl/spimsp_sync.sv ====
// =====================================================================
// Two-stage synchroniser for four independent levels.
module spimsp_sync (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset_n,
   // Asynchronous levels in, synchronised levels out.
   input wire logic [3:0] din,
   output logic [3:0] dout
);
   spimsp_pkg::spimsp_sync_s st; // Present stages.
   spimsp_pkg::spimsp_sync_s next_st; // Next stages.

   // The first stage is read only by the second stage.
   always_comb begin
      next_st = st;
      next_st.stage1 = din;
      next_st.stage2 = st.stage1;
   end

   // Registers the stages.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dout = st.stage2;
endmodule : spimsp_sync

// ==== rtl/spimsp_slave_link.sv ====
`include "spimsp_defines.svh"

// =====================================================================
// Slave receive logic clocked on the sampling edge of the link clock.
module spimsp_slave_link (
   // Link clock and its reset, which also clears the bit counter.
   input wire logic link_clk,
   input wire logic link_rst_n,
   // Serial data from the master.
   input wire logic mosi_in,
   // Results towards the core side.
   spimsp_link_if.link lnk
);
   spimsp_pkg::spimsp_link_s st; // Present link state.
   spimsp_pkg::spimsp_link_s next_st; // Next link state.

   // Counts sampling edges and shifts data in, most significant bit first.
   always_comb begin
      next_st = st;
      next_st.bit_cnt = st.bit_cnt + 3'h1;
      if (st.bit_cnt == `SPIMSP_BIT_LAST) begin
         // The eighth bit completes the byte; the toggle reports it.
         next_st.rx_hold = {st.shift_in, mosi_in};
         next_st.toggle = ~st.toggle;
      end else begin
         next_st.shift_in = {st.shift_in[5:0], mosi_in};
      end
      next_st.busy = (next_st.bit_cnt != 3'h0);
   end

   // Registers the state; reset comes from disable or a high select in multi-master mode.
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign lnk.rx_byte = st.rx_hold;
   assign lnk.rx_toggle = st.toggle;
   assign lnk.busy = st.busy;
   assign lnk.bit_cnt = st.bit_cnt;

   // The eighth sampling edge always reports a finished byte.
   AST_BIT_COUNT: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      (st.bit_cnt == `SPIMSP_BIT_LAST) |=> (st.toggle != $past(st.toggle)) && (st.bit_cnt == 3'h0))
      else $error("Byte not completed after eight bits.");
endmodule : spimsp_slave_link

// ==== rtl/spimsp_port.sv ====
`include "spimsp_defines.svh"

// Contract
// - Master when master bit set, else slave.
// - Master write loads buffer, starts shift at once.
// - Byte end sets transfer flag, may interrupt.
// - Receive shifts in MSB first into buffer.
// - Select mode bits choose master select behaviour.
// - Low select in multi-master disables, faults.
// - Three-wire modes ignore and never drive select.
// - Four-wire master drives select from low bit.
// - Slave counts eight edges, then completes byte.
// - Slave never starts; transmit is double-buffered.
// - Multi-master slave active only while select low.
// - Three-wire slave counter reset only by disable.
// - Four flags interrupt when enabled, stay until cleared.
// - Write to full buffer collides, is dropped.
// - Slave overrun keeps old byte, drops new.
// - Phase and polarity bits give four modes.
// - Both ends match phase and polarity settings.
// - Rate divider used only as master, capped.
// - Polarity bit sets clock idle level.
// - Phase bit picks first or second edge.
// - Data out released when disabled or, in multi-master, unselected.
// - Busy bit shows any transfer in progress.

// =====================================================================
// Byte-wide full-duplex serial port, master or slave.
module spimsp_port (
   // Core clock and reset.
   input wire logic core_clk,
   input wire logic reset_n,
   // Enable bits, written together; hardware may clear them.
   input wire logic ctrl_write,
   input wire logic ctrl_master_enable,
   input wire logic ctrl_port_enable,
   output logic master_enable_bit,
   output logic port_enable_bit,
   // Static configuration.
   input wire logic clock_phase_bit,
   input wire logic clock_polarity_bit,
   input wire logic select_mode_hi,
   input wire logic select_mode_lo,
   input wire logic [7:0] serial_clock_rate_register,
   input wire logic interrupt_enable,
   // Data register access.
   input wire logic data_write,
   input wire logic [7:0] write_data,
   input wire logic data_read,
   output logic [7:0] serial_data_register,
   // Flags, their clear strobes and the interrupt request.
   input wire logic [3:0] flag_clear,
   output logic transfer_complete_flag,
   output logic write_collision_flag,
   output logic mode_fault_flag,
   output logic receive_overrun_flag,
   output logic transfer_busy_bit,
   output logic irq,
   // Serial clock pin.
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   // Master-out data pin.
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   // Master-in data pin.
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   // Select pin.
   input wire logic nss_in,
   output logic nss_out,
   output logic nss_oe
);
   // =====================================================================
   // Declarations.
   spimsp_pkg::spimsp_core_s st; // Present core state.
   spimsp_pkg::spimsp_core_s next_st; // Next core state.
   logic [3:0] sync_d; // Levels entering the synchroniser.
   logic [3:0] sync_q; // Synchronised levels.
   logic [1:0] select_mode; // Both select mode bits.
   logic fault; // Mode fault condition this cycle.
   logic byte_event; // Slave byte reported by the link side.
   logic [3:0] set_flags; // Flags raised this cycle.
   logic [3:0] kept_flags; // Flags that no clear touches this cycle.
   logic [4:0] edge_num; // Number of the master clock edge being made.
   logic [7:0] half_limit; // Last count of a master half period.
   logic link_clk; // Sampling edge of the link clock is its rising edge.
   logic link_rst_n; // Holds the link logic while it must not count.
   spimsp_link_if lnk (); // Link results towards the core.

   // =====================================================================
   // Functions.

   // Shifts one bit into a byte at its low end.
   function automatic logic [7:0] shift_bit(input logic [7:0] value, input logic in_bit);
      shift_bit = {value[6:0], in_bit};
   endfunction : shift_bit

   // Limits the rate divider so that the master never beats the bit-rate cap.
   function automatic logic [7:0] limit_rate(input logic [7:0] rate);
      if (({1'b0, rate} + 9'h001) < 9'(`SPIMSP_MIN_HALF)) begin
         limit_rate = 8'(`SPIMSP_MIN_HALF - 1);
      end else begin
         limit_rate = rate;
      end
   endfunction : limit_rate

   // =====================================================================
   // Select, master-in data, link toggle and link busy pass two flip-flops before core logic.
   assign sync_d[`SPIMSP_SYNC_NSS] = nss_in;
   assign sync_d[`SPIMSP_SYNC_MISO] = miso_in;
   assign sync_d[`SPIMSP_SYNC_TOGGLE] = lnk.rx_toggle;
   assign sync_d[`SPIMSP_SYNC_BUSY] = lnk.busy;

   spimsp_sync u_sync (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .din(sync_d),
      .dout(sync_q)
   );

   // =====================================================================
   // Link side.

   // Polarity and phase together pick which pin edge samples data.
   // Software must give the far end the same phase and polarity as these bits.
   assign link_clk = sck_in ^ clock_polarity_bit ^ clock_phase_bit;
   // The link counts only as an enabled slave, and in multi-master mode only while selected.
   assign link_rst_n = reset_n & st.port_en & ~st.master_en &
      ~((select_mode == `SPIMSP_MODE_MULTI) & nss_in);

   spimsp_slave_link u_link (
      .link_clk(link_clk),
      .link_rst_n(link_rst_n),
      .mosi_in(mosi_in),
      .lnk(lnk)
   );

   // =====================================================================
   // Core decode.
   assign select_mode = {select_mode_hi, select_mode_lo};
   // Low select in multi-master mode takes the bus away from this master.
   assign fault = st.port_en & st.master_en & (select_mode == `SPIMSP_MODE_MULTI) &
      ~sync_q[`SPIMSP_SYNC_NSS];
   assign byte_event = sync_q[`SPIMSP_SYNC_TOGGLE] != st.toggle_seen;
   assign half_limit = limit_rate(serial_clock_rate_register);
   assign edge_num = st.edge_cnt + 5'h01;
   assign kept_flags = st.flags & ~flag_clear;

   // =====================================================================
   // Core next-state logic.
   always_comb begin
      next_st = st;
      set_flags = 4'h0;
      next_st.toggle_seen = sync_q[`SPIMSP_SYNC_TOGGLE];
      // Software writes both enable bits at once.
      if (ctrl_write) begin
         next_st.master_en = ctrl_master_enable;
         next_st.port_en = ctrl_port_enable;
      end
      // A write while the buffer still waits is refused.
      if (data_write) begin
         if (st.tx_full) begin
            set_flags[`SPIMSP_FLAG_COLLIDE] = 1'b1;
         end else begin
            next_st.tx_buf = write_data;
            next_st.tx_full = 1'b1;
         end
      end
      // Reading the data register frees the receive buffer.
      if (data_read) begin
         next_st.rx_full = 1'b0;
      end
      if (!st.port_en) begin
         // A disabled port idles with its clock at the idle level.
         next_st.state = spimsp_pkg::spimsp_st_idle;
         next_st.sck = clock_polarity_bit;
         next_st.edge_cnt = 5'h00;
         next_st.div_cnt = 8'h00;
         next_st.shift_loaded = 1'b0;
      end else if (st.master_en) begin
         if (fault) begin
            // Mode fault drops both enables and stops any byte.
            next_st.master_en = 1'b0;
            next_st.port_en = 1'b0;
            set_flags[`SPIMSP_FLAG_FAULT] = 1'b1;
            next_st.state = spimsp_pkg::spimsp_st_idle;
            next_st.sck = clock_polarity_bit;
         end else begin
            case (st.state)
               spimsp_pkg::spimsp_st_idle: begin
                  // A waiting byte starts a transfer at once.
                  next_st.sck = clock_polarity_bit;
                  if (st.tx_full) begin
                     next_st.shift = st.tx_buf;
                     next_st.tx_full = 1'b0;
                     next_st.state = spimsp_pkg::spimsp_st_run;
                     next_st.div_cnt = 8'h00;
                     next_st.edge_cnt = 5'h00;
                  end
               end
               spimsp_pkg::spimsp_st_run: begin
                  if (st.div_cnt >= half_limit) begin
                     // One half period over: make the next clock edge.
                     next_st.div_cnt = 8'h00;
                     next_st.sck = ~st.sck;
                     next_st.edge_cnt = edge_num;
                     if (edge_num == `SPIMSP_LAST_EDGE) begin
                        // The sixteenth edge closes the byte.
                        next_st.shift = shift_bit(st.shift, clock_phase_bit ?
                           sync_q[`SPIMSP_SYNC_MISO] : st.sample_bit);
                        next_st.rx_buf = next_st.shift;
                        next_st.rx_full = 1'b1;
                        set_flags[`SPIMSP_FLAG_DONE] = 1'b1;
                        next_st.state = spimsp_pkg::spimsp_st_idle;
                     end else if (edge_num[0] ^ clock_phase_bit) begin
                        // Sampling edge: odd edges with phase clear, even with it set.
                        next_st.sample_bit = sync_q[`SPIMSP_SYNC_MISO];
                     end else if (edge_num != `SPIMSP_FIRST_EDGE) begin
                        // Shifting edge moves the next bit onto the output.
                        next_st.shift = shift_bit(st.shift, st.sample_bit);
                     end
                  end else begin
                     next_st.div_cnt = st.div_cnt + 8'h01;
                  end
               end
               default: begin
                  next_st.state = spimsp_pkg::spimsp_st_idle;
               end
            endcase
         end
      end else begin
         // Slave: the master owns all timing; the rate divider is unused.
         next_st.state = spimsp_pkg::spimsp_st_idle;
         next_st.sck = clock_polarity_bit;
         if (byte_event) begin
            set_flags[`SPIMSP_FLAG_DONE] = 1'b1;
            if (st.rx_full && !data_read) begin
               set_flags[`SPIMSP_FLAG_OVERRUN] = 1'b1;
            end else begin
               next_st.rx_buf = lnk.rx_byte;
               next_st.rx_full = 1'b1;
            end
            next_st.shift_loaded = 1'b0;
         end
         // An empty shift register takes the waiting byte at once.
         if (!next_st.shift_loaded && st.tx_full) begin
            next_st.shift = st.tx_buf;
            next_st.shift_loaded = 1'b1;
            next_st.tx_full = 1'b0;
         end
      end
      // A flag raised in the cycle of its clear stays raised.
      next_st.flags = kept_flags | set_flags;
   end

   // =====================================================================
   // Core state register.
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // =====================================================================
   // Outputs.
   assign master_enable_bit = st.master_en;
   assign port_enable_bit = st.port_en;
   assign serial_data_register = st.rx_buf;
   assign transfer_complete_flag = st.flags[`SPIMSP_FLAG_DONE];
   assign write_collision_flag = st.flags[`SPIMSP_FLAG_COLLIDE];
   assign mode_fault_flag = st.flags[`SPIMSP_FLAG_FAULT];
   assign receive_overrun_flag = st.flags[`SPIMSP_FLAG_OVERRUN];
   assign irq = interrupt_enable & (|st.flags);
   // Busy follows the sequencer as master and the link counter as slave.
   assign transfer_busy_bit = st.master_en ? (st.state == spimsp_pkg::spimsp_st_run) :
      (st.port_en & sync_q[`SPIMSP_SYNC_BUSY]);
   // Master drives clock and data out.
   assign sck_out = st.sck;
   assign sck_oe = st.port_en & st.master_en;
   assign mosi_out = st.shift[7];
   assign mosi_oe = st.port_en & st.master_en;
   // Slave data out follows the bit counter, most significant bit first.
   assign miso_out = st.shift[`SPIMSP_BIT_LAST - lnk.bit_cnt];
   assign miso_oe = st.port_en & ~st.master_en &
      ((select_mode != `SPIMSP_MODE_MULTI) | ~sync_q[`SPIMSP_SYNC_NSS]);
   // Select is an output only for a four-wire master; three-wire leaves it alone.
   assign nss_out = select_mode_lo;
   assign nss_oe = st.port_en & st.master_en & select_mode_hi;

   // =====================================================================
   // Assertions.
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // An idle enabled master with a free buffer takes a write.
   sequence seq_master_write;
      st.port_en && st.master_en && !fault && (st.state == spimsp_pkg::spimsp_st_idle) &&
         !st.tx_full && data_write && !ctrl_write;
   endsequence

   // The edge that closes a master byte.
   sequence seq_last_edge;
      st.port_en && st.master_en && !fault && (st.state == spimsp_pkg::spimsp_st_run) &&
         (st.div_cnt >= half_limit) && (edge_num == `SPIMSP_LAST_EDGE);
   endsequence

   AST_MASTER_START: assert property (seq_master_write ##1 (!fault && !ctrl_write) |=>
      (st.state == spimsp_pkg::spimsp_st_run) && transfer_busy_bit)
      else $error("Master did not start after a write.");

   AST_BYTE_DONE: assert property (seq_last_edge |=>
      transfer_complete_flag && st.rx_full && (st.state == spimsp_pkg::spimsp_st_idle))
      else $error("Master byte end did not raise the transfer flag.");

   AST_FLAG_STICKY: assert property (1'b1 |=>
      ((st.flags & $past(kept_flags)) == $past(kept_flags)))
      else $error("A flag fell without a clear.");

   AST_COLLISION: assert property (data_write && st.tx_full |=>
      write_collision_flag && $stable(st.tx_buf))
      else $error("Colliding write was not refused.");

   AST_FAULT_OFF: assert property (fault |=>
      !master_enable_bit && !port_enable_bit && mode_fault_flag && !sck_oe)
      else $error("Mode fault did not disable the port.");

   AST_SCK_IDLE: assert property (st.port_en && st.master_en &&
      (st.state == spimsp_pkg::spimsp_st_idle) && $stable(clock_polarity_bit) |-> sck_out == clock_polarity_bit)
      else $error("Idle clock at the wrong level.");

   AST_OVERRUN: assert property (!st.master_en && st.port_en && byte_event && st.rx_full && !data_read |=>
      receive_overrun_flag && $stable(serial_data_register))
      else $error("Overrun did not keep the old byte.");

   AST_MISO_Z: assert property (!st.port_en || st.master_en |-> !miso_oe)
      else $error("Data out driven while not an enabled slave.");

   AST_NSS_OUT: assert property (nss_oe |-> select_mode_hi && (nss_out == select_mode_lo) && st.master_en)
      else $error("Select driven outside four-wire master mode.");

   AST_BUSY_RUN: assert property ((st.state == spimsp_pkg::spimsp_st_run) && st.master_en |->
      transfer_busy_bit ##1 (transfer_busy_bit || (st.state == spimsp_pkg::spimsp_st_idle)))
      else $error("Busy low during a master transfer.");
endmodule : spimsp_port

// ==== sim/spimsp_far_end.sv ====
// =====================================================================
// Far end of the link: a slave for the port as master, a master for it as slave.
module spimsp_far_end (
   // Clock and data from the port as master.
   input wire logic sck,
   input wire logic mosi,
   // Lines driven towards the port.
   output logic miso,
   output logic m_sck,
   output logic m_mosi,
   output logic m_nss
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] s_sh; // Slave shift register, loaded by the bench.
   logic [7:0] s_rx; // Bits seen on the master data line.
   initial begin
      s_sh = 8'h00;
      s_rx = 8'h00;
      m_sck = 1'b0;
      m_mosi = 1'b0;
      m_nss = 1'b1;
   end
   // Slave data goes out most significant bit first.
   assign miso = s_sh[7];
   // Same phase and polarity as the port: sample rising, shift falling.
   always @(posedge sck) s_rx <= {s_rx[6:0], mosi};
   always @(negedge sck) s_sh <= {s_sh[6:0], ~s_sh[0]};
   // One byte as master; the clock runs only inside the frame.
   task send(input logic [7:0] b);
      m_nss = 1'b0;
      #120;
      for (int i = 7; i >= 0; i--) begin
         m_mosi = b[i];
         #24 m_sck = 1'b1;
         #24 m_sck = 1'b0;
      end
      #120 m_nss = 1'b1;
      m_mosi = ~m_mosi;
   endtask : send
endmodule : spimsp_far_end

// ==== sim/spi_master_slave_port_tb.sv ====
// =====================================================================
// Bench: port as master and as slave against the far-end model.
module spi_master_slave_port_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, reset_n, ctrl_write, ctrl_m, ctrl_p, interrupt_enable, data_write, data_read;
   logic select_mode_hi, select_mode_lo, nss_ok;
   logic [7:0] write_data, serial_data_register;
   logic [3:0] flag_clear;
   logic me, pe, done, col, flt, ovr, busy, irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
   logic nss_out, nss_oe, miso, m_sck, m_mosi, m_nss;
   int num_errors = 0;
   int compares = 0;
   wire logic [4:0] ev = {busy, ovr, flt, col, done}; // Events polled by waits.
   spimsp_port dut (.core_clk, .reset_n, .ctrl_write, .ctrl_master_enable(ctrl_m), .ctrl_port_enable(ctrl_p),
      .master_enable_bit(me), .port_enable_bit(pe), .clock_phase_bit(1'b0), .clock_polarity_bit(1'b0),
      .select_mode_hi, .select_mode_lo, .serial_clock_rate_register(8'h03), .interrupt_enable,
      .data_write, .write_data, .data_read, .serial_data_register, .flag_clear, .transfer_complete_flag(done),
      .write_collision_flag(col), .mode_fault_flag(flt), .receive_overrun_flag(ovr), .transfer_busy_bit(busy),
      .irq, .sck_in(sck_oe ? sck_out : m_sck), .sck_out, .sck_oe, .mosi_in(mosi_oe ? mosi_out : m_mosi),
      .mosi_out, .mosi_oe, .miso_in(miso), .miso_out, .miso_oe, .nss_in(nss_oe ? nss_out : (m_nss & nss_ok)),
      .nss_out, .nss_oe);
   spimsp_far_end far (.sck(sck_out), .mosi(mosi_out), .miso, .m_sck, .m_mosi, .m_nss);
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // Ends the run with the counts and the verdict.
   task final_report;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   // Compares a settled value with its expectation.
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Waits a bounded time for one event bit.
   task wt(input int idx);
      for (int i = 0; i < 600; i++) begin
         @(negedge core_clk);
         if (ev[idx] === 1'b1) return;
      end
      num_errors++;
      $display("wrong value at %0t: event %0d never came", $time, idx);
      final_report();
   endtask : wt
   // One-cycle strobes on the register ports.
   task ctl(input logic m, input logic p);
      @(posedge core_clk);
      ctrl_write <= 1'b1;
      ctrl_m <= m;
      ctrl_p <= p;
      @(posedge core_clk);
      ctrl_write <= 1'b0;
   endtask : ctl
   task wr(input logic [7:0] b);
      @(posedge core_clk);
      data_write <= 1'b1;
      write_data <= b;
      @(posedge core_clk);
      data_write <= 1'b0;
   endtask : wr
   task pulse(input logic [3:0] m, input logic r);
      @(posedge core_clk);
      flag_clear <= m;
      data_read <= r;
      @(posedge core_clk);
      flag_clear <= 4'h0;
      data_read <= 1'b0;
      @(negedge core_clk);
   endtask : pulse
   // =====================================================================
   // Main sequence.
   initial begin
      {reset_n, ctrl_write, ctrl_m, ctrl_p, data_write, data_read, select_mode_hi, select_mode_lo} = 8'h00;
      {write_data, flag_clear, nss_ok, interrupt_enable} = 14'h0003;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      @(negedge core_clk);
      chk({ovr, flt, col, done, me, pe, miso_oe, sck_oe}, 8'h00);
      ctl(1'b1, 1'b1);
      far.s_sh = 8'h3C;
      wr(8'hA5);
      wt(4);
      wr(8'h11);
      wr(8'h22);
      wt(1);
      wt(0);
      chk(serial_data_register, 8'h3C);
      chk(far.s_rx, 8'hA5);
      chk({6'h00, irq, nss_oe}, 8'h02);
      pulse(4'h1, 1'b1);
      wt(0);
      chk(far.s_rx, 8'h11);
      chk({7'h00, sck_out}, 8'h00);
      pulse(4'hF, 1'b1);
      chk({7'h00, irq}, 8'h00);
      @(posedge core_clk);
      select_mode_hi <= 1'b1;
      select_mode_lo <= 1'b1;
      repeat (2) @(negedge core_clk);
      chk({6'h00, nss_oe, nss_out}, 8'h03);
      ctl(1'b0, 1'b0);
      select_mode_hi <= 1'b0;
      nss_ok <= 1'b0;
      ctl(1'b1, 1'b1);
      wt(2);
      chk({5'h00, me, pe, irq}, 8'h01);
      nss_ok <= 1'b1;
      select_mode_lo <= 1'b0;
      pulse(4'hF, 1'b1);
      ctl(1'b0, 1'b1);
      wr(8'hC3);
      repeat (2) @(negedge core_clk);
      chk({6'h00, miso_oe, miso_out}, 8'h03);
      far.send(8'h96);
      wt(0);
      chk(serial_data_register, 8'h96);
      pulse(4'h1, 1'b0);
      far.send(8'h5A);
      wt(3);
      chk(serial_data_register, 8'h96);
      final_report();
   end
endmodule : spi_master_slave_port_tb
